// ### hw/ctp_timer_pair.v
// two cascadable 8-bit interval timers with a 16-bit cascade
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
`include "ctp_defs.vh"
module ctp_timer_pair (
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    input wire divider_chain_select,
    input wire low_freq_clock,
    input wire lower_count_pin,
    input wire upper_count_pin,
    input wire [2:0] lower_mode_field,
    input wire [2:0] lower_clock_select,
    input wire lower_run_bit,
    input wire [7:0] lower_period_compare,
    input wire [2:0] upper_mode_field,
    input wire [2:0] upper_clock_select,
    input wire upper_run_bit,
    input wire upper_flipflop_init,
    input wire [7:0] upper_period_compare,
    output reg [7:0] lower_count_q,
    output reg [7:0] upper_count_q,
    output reg lower_match_irq,
    output reg upper_match_irq,
    output reg upper_flipflop_q
);
// ==========================================================
// synchronisers for pin-side inputs
reg [2:0] sync1_q;
reg [2:0] sync2_q;
reg [2:0] sync3_q;
always @(posedge ref_clk) begin
    if (rst) begin
        sync1_q <= 3'h0;
        sync2_q <= 3'h0;
        sync3_q <= 3'h0;
    end else if (clk_en) begin
        sync1_q <= {low_freq_clock, lower_count_pin, upper_count_pin};
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end
end
// low clock rising edge, pins count on falling edges
wire low_tick = sync2_q[2] & ~sync3_q[2];
wire lower_pin_tick = ~sync2_q[1] & sync3_q[1];
wire upper_pin_tick = ~sync2_q[0] & sync3_q[0];
// ==========================================================
// prescaler chains
reg [10:0] pre_q;
reg [2:0] low_pre_q;
reg [10:0] pre_prev_q;
reg [2:0] low_prev_q;
always @(posedge ref_clk) begin
    if (rst) begin
        pre_q <= `CTP_PRE_RST;
        pre_prev_q <= `CTP_PRE_RST;
        low_pre_q <= 3'h0;
        low_prev_q <= 3'h0;
    end else if (clk_en) begin
        pre_q <= pre_q + 11'h001;
        pre_prev_q <= pre_q;
        if (low_tick) begin
            low_pre_q <= low_pre_q + 3'h1;
        end
        low_prev_q <= low_pre_q;
    end
end
// one-cycle tick on the falling edge of each prescaler bit
wire [10:0] pre_fall = pre_prev_q & ~pre_q;
wire low8_tick = low_prev_q[`CTP_TAP_LOW3] & ~low_pre_q[`CTP_TAP_LOW3];
wire slow_tick = divider_chain_select ? low8_tick : pre_fall[`CTP_TAP_DIV11];

// select decode
// every tick source is an argument, so the function reads no module signal
function sel_tick;
    input [2:0] sel;
    input [10:0] falls;
    input slow;
    input low;
    input pin_tick;
    begin
        case (sel)
            `CTP_CK_SLOW: sel_tick = slow;
            `CTP_CK_DIV7: sel_tick = falls[`CTP_TAP_DIV7];
            `CTP_CK_DIV5: sel_tick = falls[`CTP_TAP_DIV5];
            `CTP_CK_DIV3: sel_tick = falls[`CTP_TAP_DIV3];
            `CTP_CK_LOW: sel_tick = low;
            `CTP_CK_DIV1: sel_tick = falls[`CTP_TAP_DIV1];
            `CTP_CK_HIGH: sel_tick = 1'b1;
            default: sel_tick = pin_tick;
        endcase
    end
endfunction

// ==========================================================
// counters
// only the top bit of the upper mode field steers the datapath; the other
// mode codes all run as interval timers until their own logic is added
wire cascade = upper_mode_field[`CTP_MODE16_BIT];
// cascade run comes from the upper run bit
// while cascaded the lower run bit is ignored, so one write starts both bytes
wire lower_run = cascade ? upper_run_bit : lower_run_bit;
wire lower_tick = sel_tick(lower_clock_select, pre_fall, slow_tick, low_tick,
    lower_pin_tick);
// the upper byte's own select is ignored while cascaded
wire upper_own_tick = sel_tick(upper_clock_select, pre_fall, slow_tick, low_tick,
    upper_pin_tick);
// a selected tick while running advances the count
wire lower_inc = lower_run & lower_tick;
// in cascade the upper byte is clocked only by the lower wrap
wire lower_wrap = cascade & lower_inc & (lower_count_q == 8'hFF);
wire upper_tick = cascade ? lower_wrap : upper_own_tick;
wire upper_inc = upper_run_bit & upper_tick;

// ==========================================================
// compare
// a match is taken on the tick that would bring the count up to the compare
// value, so a compare of n from 1 to 255 gives a period of exactly n ticks and
// 0 gives 256; the count itself never shows a nonzero compare value
// limitation: a compare written below the running count is only met after
// the count wraps past 0xFF
wire [7:0] lower_next = lower_count_q + 8'h01;
wire [7:0] upper_next = upper_count_q + 8'h01;
wire [15:0] word_now = {upper_count_q, lower_count_q};
wire [15:0] word_cmp = {upper_period_compare, lower_period_compare};
wire [15:0] word_next = word_now + 16'h0001;
// compare inputs are used directly, with no shadow copy
wire lower_hit = ~cascade & (lower_next == lower_period_compare);
wire upper_hit = ~cascade & (upper_next == upper_period_compare);
// 16-bit period end compares both bytes as one word
wire word_hit = cascade & (word_next == word_cmp);

// ==========================================================
// next state
reg [7:0] lower_count_d;
reg [7:0] upper_count_d;
reg lower_irq_d;
reg upper_irq_d;
reg flipflop_d;
always @* begin
    // defaults hold the counts and the flip-flop and zero both irqs, so a running cycle without a tick only ends an irq pulse
    lower_count_d = lower_count_q;
    upper_count_d = upper_count_q;
    lower_irq_d = 1'b0;
    upper_irq_d = 1'b0;
    flipflop_d = upper_flipflop_q;
    if (!lower_run) begin
        lower_count_d = `CTP_CNT_RST;
    // match raises irq and clears; the lower irq stays quiet in cascade
    end else if (lower_inc && (lower_hit || word_hit)) begin
        lower_count_d = `CTP_CNT_RST;
        lower_irq_d = lower_hit;
    // counting carries on from zero with no software help
    end else if (lower_inc) begin
        lower_count_d = lower_next;
    end
    // flip-flop loads only while stopped, so a stop write reloads it from upper_flipflop_init
    // limitation: nothing toggles it yet; the outputs that would are later work
    if (!upper_run_bit) begin
        upper_count_d = `CTP_CNT_RST;
        flipflop_d = upper_flipflop_init;
    // word match clears both bytes and raises the upper irq
    // a wrap and a word match on one tick: the match wins
    end else if (lower_inc && word_hit) begin
        upper_count_d = `CTP_CNT_RST;
        upper_irq_d = 1'b1;
    end else if (upper_inc && upper_hit) begin
        upper_count_d = `CTP_CNT_RST;
        upper_irq_d = 1'b1;
    end else if (upper_inc) begin
        upper_count_d = upper_next;
    end
end

// ==========================================================
// registers
// clk_en low freezes every flop, prescalers included, so a paused timer
// resumes exactly where it stopped
// irq outputs are one-cycle pulses, rebuilt from zero each enabled edge
always @(posedge ref_clk) begin
    if (rst) begin
        lower_count_q <= `CTP_CNT_RST;
        upper_count_q <= `CTP_CNT_RST;
        lower_match_irq <= 1'b0;
        upper_match_irq <= 1'b0;
        upper_flipflop_q <= 1'b0;
    end else if (clk_en) begin
        lower_count_q <= lower_count_d;
        upper_count_q <= upper_count_d;
        lower_match_irq <= lower_irq_d;
        upper_match_irq <= upper_irq_d;
        upper_flipflop_q <= flipflop_d;
    end
end
endmodule // ctp_timer_pair
`default_nettype wire

// ### inc/ctp_defs.vh
// constants for the cascadable timer pair
`ifndef CTP_DEFS_VH
`define CTP_DEFS_VH
// clock select codes
`define CTP_CK_SLOW 3'h0
`define CTP_CK_DIV7 3'h1
`define CTP_CK_DIV5 3'h2
`define CTP_CK_DIV3 3'h3
`define CTP_CK_LOW 3'h4
`define CTP_CK_DIV1 3'h5
`define CTP_CK_HIGH 3'h6
`define CTP_CK_PIN 3'h7
// prescaler tap positions (high clock divided by 2^(n+1))
`define CTP_TAP_DIV11 10
`define CTP_TAP_DIV7 6
`define CTP_TAP_DIV5 4
`define CTP_TAP_DIV3 2
`define CTP_TAP_DIV1 0
// low clock divided by 8
`define CTP_TAP_LOW3 2
// mode codes
`define CTP_MODE_TIMER 3'h0
`define CTP_MODE_LOWER16 3'h3
`define CTP_MODE16_BIT 2
// reset values
`define CTP_CNT_RST 8'h00
`define CTP_PRE_RST 11'h000
`endif

// ### sim/ctp_timer_pair_assertions.sv
// assertions for the timer pair
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_pair_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic lower_run_bit,
    input wire logic upper_run_bit,
    input wire logic lower_match_irq,
    input wire logic [2:0] lower_clock_select,
    input wire logic [2:0] upper_mode_field,
    input wire logic [7:0] lower_period_compare,
    input wire logic [7:0] lower_count_q,
    input wire logic [7:0] upper_count_q
);
    wire l8 = clk_en & ~upper_mode_field[2];
    wire c16 = clk_en & upper_mode_field[2];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ====================
    // full-rate tick away from the compare value
    sequence s_fast;
        l8 && lower_run_bit && lower_clock_select == 3'h6 &&
        lower_count_q != lower_period_compare &&
        lower_count_q + 8'h01 != lower_period_compare;
    endsequence
    chk_fast_inc: assert property (s_fast |=> lower_count_q == $past(lower_count_q) + 8'h01)
        else $error("count did not step");
    chk_lower_stop: assert property (l8 && !lower_run_bit |=> lower_count_q == 8'h00)
        else $error("stopped count not zero");
    chk_stop_quiet: assert property (l8 && !lower_run_bit |=> !lower_match_irq)
        else $error("irq while stopped");
    chk_upper_stop: assert property (clk_en && !upper_run_bit |=> upper_count_q == 8'h00)
        else $error("upper stopped count not zero");
    chk_casc_stop: assert property (c16 && !upper_run_bit |=> lower_count_q == 8'h00)
        else $error("cascade stop ignored");
    chk_irq_zero: assert property (lower_match_irq |-> lower_count_q == 8'h00)
        else $error("irq without clear");
    chk_casc_quiet: assert property (c16 |=> !lower_match_irq)
        else $error("lower irq in cascade");
    // the upper half may only move on a lower wrap or a full match
    chk_casc_carry: assert property (c16 && upper_run_bit && lower_count_q != 8'hFF &&
        lower_count_q + 8'h01 != lower_period_compare |=> $stable(upper_count_q))
        else $error("upper moved without carry");
endmodule // ctp_timer_pair_chk
bind ctp_timer_pair ctp_timer_pair_chk i_chk (.*);
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the timer pair
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 0, rst = 1, clk_en = 1, divider_chain_select = 0;
    logic low_freq_clock = 0, lower_count_pin = 1, upper_count_pin = 1;
    logic lower_run_bit = 0, upper_run_bit = 0, upper_flipflop_init = 0;
    logic [2:0] lower_mode_field = 0, lower_clock_select = 0;
    logic [2:0] upper_mode_field = 0, upper_clock_select = 0;
    logic [7:0] lower_period_compare = 0, upper_period_compare = 0;
    logic [7:0] lower_count_q, upper_count_q;
    logic lower_match_irq, upper_match_irq, upper_flipflop_q;
    int n_fail = 0, cmp_count = 0, cyc = 0, n, k = 0;
    logic [2:0] sl [6] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0};
    int dv [6] = '{1, 2, 8, 32, 128, 2048};
    ctp_timer_pair i_ctp_timer_pair (.*);
    always #4 ref_clk = ~ref_clk;
    // free-running low clock of 32 cycles; count pins fall every 8 cycles
    always @(negedge ref_clk) begin
        k++;
        if (k % 16 == 0) low_freq_clock <= ~low_freq_clock;
        if (k % 4 == 0) {lower_count_pin, upper_count_pin} <= ~{lower_count_pin, upper_count_pin};
    end
    // ====================
    // tasks
    task print_verdict;
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wirq(input bit u);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((u ? upper_match_irq : lower_match_irq) !== 1'b1);
    endtask
    // start both counters in one write, time two interrupts, stop
    task per(input bit u, input logic [2:0] s, input logic [7:0] c, input int e);
        lower_clock_select = s;
        upper_clock_select = s;
        lower_period_compare = c;
        upper_period_compare = c;
        lower_run_bit = 1;
        upper_run_bit = 1;
        wirq(u);
        wirq(u);
        chk(n, e);
        lower_run_bit = 0;
        upper_run_bit = 0;
        @(negedge ref_clk);
        chk({lower_count_q, upper_count_q}, 0);
    endtask
    // ====================
    // hang guard, well above the longest run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 50000) begin
            n_fail++;
            print_verdict;
        end
    end
    initial begin
        repeat (4) @(negedge ref_clk);
        rst = 0;
        for (int i = 0; i < 6; i++) begin
            // 110 and 101 are legal only for the PWM code, which counts as a timer here
            lower_mode_field = (i < 2) ? 3'h2 : 3'h0;
            upper_mode_field = lower_mode_field;
            per(0, sl[i], 8'h03, 3 * dv[i]);
        end
        lower_mode_field = 3'h0;
        upper_mode_field = 3'h0;
        per(1, 3'h3, 8'hFF, 2040);
        per(0, 3'h3, 8'h01, 8);
        divider_chain_select = 1;
        per(0, 3'h0, 8'h03, 768);
        divider_chain_select = 0;
        per(1, 3'h7, 8'h03, 24);
        lower_clock_select = 3'h3;
        lower_period_compare = 8'hFF;
        lower_run_bit = 1;
        repeat (40) @(negedge ref_clk);
        // a new compare value must act on the running count
        lower_period_compare = 8'h0A;
        wirq(0);
        chk(n < 64, 1);
        lower_run_bit = 0;
        @(negedge ref_clk);
        lower_mode_field = 3'h3;
        upper_mode_field = 3'h4;
        // the cascade runs as a plain 16-bit timer, no duty value involved
        per(1, 3'h3, 8'h02, 4112);
        upper_flipflop_init = 1;
        @(negedge ref_clk);
        chk(upper_flipflop_q, 1);
        upper_flipflop_init = 0;
        print_verdict;
    end
endmodule // tb_top
`default_nettype wire
